// File: logic/agc_pkg.sv
package agc_pkg;
    // Host command and data codes
    localparam logic [7:0] CMD_WRITE_OUTPUT_PORT = 8'hD1;
    localparam logic [7:0] CMD_PULSE_NOP = 8'hFF;
    localparam int GATE_BIT_POS = 1;
    localparam int GATE_PIN_POS = 1;
    // Register map over AHB-Lite
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_DATA = 8'h08;
    localparam logic [7:0] ADDR_PORT2 = 8'h0C;
    localparam int CTRL_ENABLE_POS = 0;
    localparam int CTRL_CLR_FULL_POS = 1;
    localparam int STAT_FULL_POS = 0;
    localparam int STAT_ENABLED_POS = 1;
    localparam int STAT_CMD_POS = 2;
    localparam int STAT_PEND_POS = 3;
    localparam int STAT_GATE_POS = 4;
    localparam logic [7:0] PORT2_RESET = 8'hFF;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    typedef enum logic [0:0] {AGC_IDLE, AGC_PENDING} agc_seq_e;
endpackage

// File: logic/agc_sync.sv
module agc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;

    // Two flops per bit; the first one feeds only the second
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk_sys) begin
                if (!nrst) begin
                    meta_r[i] <= 1'b0;
                    q[i] <= 1'b0;
                end else begin
                    meta_r[i] <= d[i];
                    q[i] <= meta_r[i];
                end
            end
        end
    endgenerate
endmodule

// File: logic/agc_top.sv
module agc_top (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic host_cs_n,
    input wire logic host_wr_n,
    input wire logic register_select_line,
    input wire logic [7:0] host_data,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hsel,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [7:0] port2_out,
    output logic input_buffer_full_flag,
    output logic address_line_gate
);
    // ****************************************
    // Host strobe capture
    // ****************************************
    logic [10:0] raw_in;
    logic [10:0] syn;
    logic cs_n_s, wr_n_s, rs_s;
    logic [7:0] db_s;
    logic wr_act_r;
    logic [7:0] db_lat_r;
    logic rs_lat_r;
    logic wr_end;

    // Strobes enter inverted so the synchroniser's reset value is the idle level
    assign raw_in = {!host_cs_n, !host_wr_n, register_select_line, host_data};

    agc_sync #(.WIDTH(11)) u_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .d(raw_in),
        .q(syn)
    );

    assign cs_n_s = !syn[10];
    assign wr_n_s = !syn[9];
    assign rs_s = syn[8];
    assign db_s = syn[7:0];

    // Latch data while strobe active; act only once it ends
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            wr_act_r <= 1'b0;
            db_lat_r <= 8'h00;
            rs_lat_r <= 1'b0;
        end else begin
            wr_act_r <= !cs_n_s && !wr_n_s;
            if (!cs_n_s && !wr_n_s) begin
                db_lat_r <= db_s;
                rs_lat_r <= rs_s;
            end
        end
    end

    assign wr_end = wr_act_r && !(!cs_n_s && !wr_n_s);

    // ****************************************
    // Sequence interpreter
    // ****************************************
    agc_pkg::agc_seq_e seq_r;
    logic enabled_r;
    logic gate_r;
    logic buf_full_r;
    logic is_cmd, is_wopc, is_ff, take_data, swallow, set_full;
    logic [7:0] data_r;
    logic cmd_flag_r;
    logic [7:0] port2_r;
    logic fw_clr_full, fw_enable, fw_port_wr;
    logic after_data_r;

    assign is_cmd = rs_lat_r;
    assign is_wopc = db_lat_r == agc_pkg::CMD_WRITE_OUTPUT_PORT;
    assign is_ff = db_lat_r == agc_pkg::CMD_PULSE_NOP;
    // Only the first data byte after the command belongs to the sequence
    assign take_data = enabled_r && seq_r == agc_pkg::AGC_PENDING && !is_cmd
        && !after_data_r;
    // Writes that belong to a valid sequence never reach the buffer
    assign swallow = enabled_r && (
        (is_cmd && is_wopc) ||
        take_data ||
        (is_cmd && is_ff && seq_r == agc_pkg::AGC_PENDING));
    assign set_full = wr_end && !swallow;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            seq_r <= agc_pkg::AGC_IDLE;
        end else if (wr_end) begin
            if (enabled_r && is_cmd && is_wopc) begin
                seq_r <= agc_pkg::AGC_PENDING;
            end else if (take_data) begin
                // Stay armed so a trailing FFh still counts as part of the sequence
                seq_r <= agc_pkg::AGC_PENDING;
            end else begin
                seq_r <= agc_pkg::AGC_IDLE;
            end
        end
    end

    // Pending after data means FFh may close; a fresh D1h re-arms anyway
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            after_data_r <= 1'b0;
        end else if (wr_end) begin
            after_data_r <= take_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            gate_r <= 1'b0;
        end else if (wr_end && take_data && !after_data_r) begin
            gate_r <= db_lat_r[agc_pkg::GATE_BIT_POS];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            enabled_r <= 1'b0;
        end else if (fw_enable) begin
            enabled_r <= 1'b1;
        end
    end

    // Set wins over a firmware clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            buf_full_r <= 1'b0;
            data_r <= 8'h00;
            cmd_flag_r <= 1'b0;
        end else if (set_full) begin
            buf_full_r <= 1'b1;
            data_r <= db_lat_r;
            cmd_flag_r <= rs_lat_r;
        end else if (fw_clr_full) begin
            buf_full_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            port2_r <= agc_pkg::PORT2_RESET;
        end else if (fw_port_wr) begin
            port2_r <= hwdata[7:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            port2_out <= agc_pkg::PORT2_RESET;
            input_buffer_full_flag <= 1'b0;
            address_line_gate <= 1'b0;
        end else begin
            port2_out <= port2_r;
            if (enabled_r) begin
                port2_out[agc_pkg::GATE_PIN_POS] <= gate_r;
            end
            input_buffer_full_flag <= buf_full_r;
            address_line_gate <= gate_r;
        end
    end

    // ****************************************
    // AHB-Lite slave
    // ****************************************
    logic dp_wr_r, dp_rd_r;
    logic [7:0] dp_addr_r;
    logic ap_valid;
    logic [31:0] rd_val;

    assign ap_valid = hsel && hready && htrans == agc_pkg::HTRANS_NONSEQ;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            dp_wr_r <= 1'b0;
            dp_rd_r <= 1'b0;
            dp_addr_r <= 8'h00;
        end else begin
            dp_wr_r <= ap_valid && hwrite;
            dp_rd_r <= ap_valid && !hwrite;
            if (ap_valid) begin
                dp_addr_r <= haddr[7:0];
            end
        end
    end

    assign fw_enable = dp_wr_r && dp_addr_r == agc_pkg::ADDR_CTRL
        && hwdata[agc_pkg::CTRL_ENABLE_POS];
    assign fw_clr_full = dp_wr_r && dp_addr_r == agc_pkg::ADDR_CTRL
        && hwdata[agc_pkg::CTRL_CLR_FULL_POS];
    assign fw_port_wr = dp_wr_r && dp_addr_r == agc_pkg::ADDR_PORT2;

    always_comb begin
        rd_val = 32'h0000_0000;
        if (dp_addr_r == agc_pkg::ADDR_CTRL) begin
            rd_val[agc_pkg::CTRL_ENABLE_POS] = enabled_r;
        end else if (dp_addr_r == agc_pkg::ADDR_STATUS) begin
            rd_val[agc_pkg::STAT_FULL_POS] = buf_full_r;
            rd_val[agc_pkg::STAT_ENABLED_POS] = enabled_r;
            rd_val[agc_pkg::STAT_CMD_POS] = cmd_flag_r;
            rd_val[agc_pkg::STAT_PEND_POS] = seq_r == agc_pkg::AGC_PENDING;
            rd_val[agc_pkg::STAT_GATE_POS] = gate_r;
        end else if (dp_addr_r == agc_pkg::ADDR_DATA) begin
            rd_val[7:0] = data_r;
        end else if (dp_addr_r == agc_pkg::ADDR_PORT2) begin
            rd_val[7:0] = port2_out;
        end
    end

    // Read data registered: answer arrives one cycle after the data phase opens
    logic rd_wait_r;
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            rd_wait_r <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (ap_valid && !hwrite) begin
                hreadyout <= 1'b0;
                rd_wait_r <= 1'b1;
            end else if (rd_wait_r) begin
                hrdata <= rd_val;
                hreadyout <= 1'b1;
                rd_wait_r <= 1'b0;
            end
        end
    end
endmodule

// File: verification/agc_chk.sv
// ****************************************
// Port checker
// ****************************************
module agc_chk (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic host_wr_n,
    input wire logic hsel,
    input wire logic hready,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [7:0] port2_out,
    input wire logic input_buffer_full_flag,
    input wire logic address_line_gate
);
    timeunit 1ns;
    timeprecision 1ps;
    logic req;
    assign req = hsel && hready && (htrans == agc_pkg::HTRANS_NONSEQ);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    property p_rd;
        req && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd: assert property (p_rd) else $error("read answer timing wrong");
    property p_wr;
        req && hwrite |=> hreadyout;
    endproperty
    a_wr: assert property (p_wr) else $error("write stalled");
    property p_okay;
        hresp == 1'b0;
    endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    property p_full_edge;
        $rose(input_buffer_full_flag) |-> host_wr_n && $past(host_wr_n);
    endproperty
    a_full_edge: assert property (p_full_edge) else $error("flag set with strobe active");
    property p_gate_edge;
        $changed(address_line_gate) |-> host_wr_n;
    endproperty
    a_gate_edge: assert property (p_gate_edge) else $error("gate moved in strobe");
    property p_gate_pin;
        $changed(address_line_gate) |-> ##[0:2] port2_out[1] == address_line_gate;
    endproperty
    a_gate_pin: assert property (p_gate_pin) else $error("pin not following gate");
    property p_abort_hold;
        $rose(input_buffer_full_flag) |-> $stable(address_line_gate);
    endproperty
    a_abort_hold: assert property (p_abort_hold) else $error("gate moved on abort");
    property p_rst;
        @(posedge clk_sys) disable iff (1'b0)
        !nrst |=> !input_buffer_full_flag && !address_line_gate && port2_out == 8'hFF;
    endproperty
    a_rst: assert property (p_rst) else $error("reset values wrong");
endmodule

bind agc_top agc_chk chk (.clk_sys(clk_sys), .nrst(nrst), .host_wr_n(host_wr_n),
    .hsel(hsel), .hready(hready), .htrans(htrans), .hwrite(hwrite),
    .hreadyout(hreadyout), .hresp(hresp), .port2_out(port2_out),
    .input_buffer_full_flag(input_buffer_full_flag), .address_line_gate(address_line_gate));

// File: verification/agc_host.sv
// ****************************************
// Host writer model
// ****************************************
module agc_host (
    input wire logic clk_sys,
    output logic host_cs_n,
    output logic host_wr_n,
    output logic register_select_line,
    output logic [7:0] host_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        host_cs_n = 1'b1;
        host_wr_n = 1'b1;
        register_select_line = 1'b0;
        host_data = 8'hA5;
    end
    // Released bus shows inverse data so stale values cannot pass
    task automatic wr(input logic rs, input logic [7:0] d);
        @(posedge clk_sys);
        host_cs_n <= 1'b0;
        host_wr_n <= 1'b0;
        register_select_line <= rs;
        host_data <= d;
        repeat (4) @(posedge clk_sys);
        host_cs_n <= 1'b1;
        host_wr_n <= 1'b1;
        host_data <= ~d;
        repeat (10) @(posedge clk_sys);
    endtask
endmodule

// File: verification/test_address_gate_command_logic.sv
// ****************************************
// Testbench
// ****************************************
module test_address_gate_command_logic;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, full, gate, cs_n, wr_n, rs;
    logic [7:0] port2_out, hd;
    int err_count = 0;
    int tests_run = 0;
    // Row: select nibble, data byte, then full*2+gate
    logic [15:0] rows[17] = '{16'h1D10, 16'h0DF1, 16'h1FF1, 16'h1D11, 16'h0DD0, 16'h1FF0,
        16'h1D10, 16'h1D10, 16'h0DF1, 16'h1FF1, 16'h1D11, 16'h1AA3, 16'h0DD3, 16'h1FF3,
        16'h1D11, 16'h0DF1, 16'h0DD3};
    agc_host host (.clk_sys(clk_sys), .host_cs_n(cs_n), .host_wr_n(wr_n),
        .register_select_line(rs), .host_data(hd));
    agc_top dut (.clk_sys(clk_sys), .nrst(nrst), .host_cs_n(cs_n), .host_wr_n(wr_n),
        .register_select_line(rs), .host_data(hd), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hsel(hsel), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .port2_out(port2_out),
        .input_buffer_full_flag(full), .address_line_gate(gate));
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= agc_pkg::HTRANS_NONSEQ;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rst();
        nrst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        close_out();
    end
    initial begin
        rst();
        // Idle strobes must not look like a finished write after reset
        repeat (8) @(posedge clk_sys);
        chk(full, 1'b0);
        ahb(1'b1, agc_pkg::ADDR_PORT2, 32'h02);
        host.wr(1'b1, agc_pkg::CMD_WRITE_OUTPUT_PORT);
        chk(full, 1'b1);
        chk(port2_out, 8'h02);
        ahb(1'b1, agc_pkg::ADDR_CTRL, 32'h3);
        // Clear lands on the edge that closes the data phase, the output one edge later
        repeat (2) @(posedge clk_sys);
        chk(full, 1'b0);
        ahb(1'b0, agc_pkg::ADDR_STATUS, 32'h0);
        chk(rd[agc_pkg::STAT_ENABLED_POS], 1'b1);
        ahb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        foreach (rows[i]) begin
            host.wr(rows[i][12], rows[i][11:4]);
            chk(full, rows[i][1]);
            chk(gate, rows[i][0]);
            chk(port2_out[1], rows[i][0]);
            if (rows[i][1]) ahb(1'b1, agc_pkg::ADDR_CTRL, 32'h2);
        end
        ahb(1'b0, agc_pkg::ADDR_STATUS, 32'h0);
        chk(rd, 32'h12);
        ahb(1'b0, agc_pkg::ADDR_DATA, 32'h0);
        chk(rd, 32'hDD);
        ahb(1'b1, agc_pkg::ADDR_PORT2, 32'h0);
        repeat (3) @(posedge clk_sys);
        chk(port2_out, 8'h02);
        host.wr(1'b1, agc_pkg::CMD_WRITE_OUTPUT_PORT);
        rst();
        repeat (2) @(posedge clk_sys);
        chk({full, gate, port2_out}, 10'h0FF);
        repeat (8) @(posedge clk_sys);
        chk(full, 1'b0);
        ahb(1'b0, agc_pkg::ADDR_STATUS, 32'h0);
        chk(rd[agc_pkg::STAT_ENABLED_POS], 1'b0);
        ahb(1'b1, agc_pkg::ADDR_CTRL, 32'h1);
        host.wr(1'b0, 8'hDF);
        chk({full, gate}, 2'b10);
        close_out();
    end
endmodule
